// ===== design/tcu_params.svh
// Register offsets, field positions, reset values and timing counts of the capture timer
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH

`define TCU_ADDR_PORT_DATA 8'h00
`define TCU_ADDR_PORT_DIR 8'h01
`define TCU_ADDR_COUNT_HI 8'h0E
`define TCU_ADDR_COUNT_LO 8'h0F
`define TCU_ADDR_CAP1_HI 8'h10
`define TCU_ADDR_CAP1_LO 8'h11
`define TCU_ADDR_CAP2_HI 8'h12
`define TCU_ADDR_CAP2_LO 8'h13
`define TCU_ADDR_CAP3_HI 8'h14
`define TCU_ADDR_CAP3_LO 8'h15
`define TCU_ADDR_SHARED_HI 8'h1E
`define TCU_ADDR_SHARED_LO 8'h1F
`define TCU_ADDR_EDGE_CTL 8'h21
`define TCU_ADDR_CHAN_MASK 8'h22
`define TCU_ADDR_CHAN_FLAGS 8'h23
`define TCU_ADDR_OVF_MASK 8'h24
`define TCU_ADDR_OVF_FLAGS 8'h25
`define TCU_ADDR_SHARED_SEL 8'h26

`define TCU_BIT_OVF_FLAG 7
`define TCU_BIT_OVF_IRQ_EN 7
`define TCU_BIT_SHARED_DIR 3
`define TCU_BIT_CAP_CMP_SEL 2
`define TCU_SHARED_CHAN 3
`define TCU_SOFT_CAP_BIT 0

`define TCU_COUNT_MAX 16'hFFFF
`define TCU_RESET_BYTE 8'h00
`define TCU_RESET_COUNT 16'h0000
`define TCU_PRESCALE_WINDOW 7'h40

`endif

// ===== design/tcu_pkg.sv
// Types shared by the capture timer design
package tcu_pkg;
	// Edge select pair per capture channel
	typedef enum logic [1:0] {
		TCU_EDGE_OFF = 2'h0,
		TCU_EDGE_RISE = 2'h1,
		TCU_EDGE_FALL = 2'h2,
		TCU_EDGE_ANY = 2'h3
	} tcu_edge_t;

	// Prescale select field
	typedef enum logic [1:0] {
		TCU_DIV1 = 2'h0,
		TCU_DIV4 = 2'h1,
		TCU_DIV8 = 2'h2,
		TCU_DIV16 = 2'h3
	} tcu_prescale_t;

	// Terminal value of the prescale divider for a select code
	function automatic logic [3:0] tcuPrescaleTerm(input tcu_prescale_t sel);
		logic [3:0] term;
		term = 4'h0;
		case (sel)
			TCU_DIV1: term = 4'h0;
			TCU_DIV4: term = 4'h3;
			TCU_DIV8: term = 4'h7;
			TCU_DIV16: term = 4'hF;
			default: term = 4'h0;
		endcase
		return term;
	endfunction
endpackage

// ===== design/tcu_timer_capture.sv
// Free-running timer with overflow flag, prescaler and four input capture channels
// Function
// - Counter is read-only in normal mode; writable in special mode.
// - Overflow flag sets when counter wraps from all ones to zero.
// - Flags clear only by writing one to their bit; zero leaves them.
// - Overflow request raised while flag set and overflow enable is one.
// - Prescale field divides counter clock by 1, 4, 8 or 16.
// - Normal mode accepts one prescale write, only within 64 cycles of reset.
// - Port read gives pin level for inputs, driver level for outputs.
// - Port writes to timer-assigned pins are latched but do not drive.
// - Three low pins are capture inputs when enabled, otherwise general I/O.
// - With direction set and capture selected, writing one forces a capture.
// - A detected edge copies the whole counter into capture register at once.
// - Capture samples the count away from its increment so it is stable.
// - High-byte read blocks capture transfer into that register for two cycles: the read cycle and the one after.
// - Capture during either blocked cycle is held and transferred later.
// - Each selected edge sets its flag; shared only while capture selected.
// - Channel requests interrupt when enable and flag set; shared needs capture.
// - Edge pair: 00 off, 01 rising, 10 falling, 11 either edge.
// - Reset clears every edge select pair.
// - Channels are independent; same-cycle edges capture the same count.
// - Reset leaves capture register contents unchanged.
// - After reset counter counts up from zero and keeps wrapping.
`include "tcu_params.svh"

module tcu_timer_capture #(
	parameter int NUM_CHAN = 4
) (
	input wire logic core_clk, // Bus clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [7:0] regAddr, // Register byte address
	input wire logic [7:0] regWrData, // Write data
	input wire logic regWrEn, // Write strobe
	input wire logic regRdEn, // Read strobe
	output logic [7:0] regRdData, // Read data, one cycle after the strobe
	input wire logic specialMode, // Special mode level, asynchronous
	input wire logic [NUM_CHAN-1:0] portPinIn, // Port pin levels, shared pin on top
	output logic [NUM_CHAN-1:0] portPinOut, // Port pin driver levels
	output logic [NUM_CHAN-1:0] portPinOe, // Port pin output enables
	output logic overflowIrqReq, // Overflow interrupt request level
	output logic [NUM_CHAN-1:0] captureIrqReq // Channel interrupt request levels
);
	localparam int SH = `TCU_SHARED_CHAN;

	logic [15:0] freeCount_r;
	logic [3:0] preDiv_r;
	logic countTick;
	logic overflowFlag_r;
	logic overflowIrqEnable_r;
	tcu_pkg::tcu_prescale_t prescaleSelect_r;
	logic prescaleWritten_r;
	logic [6:0] bootCycles_r;
	logic [7:0] portLatch_r;
	logic [7:0] portDirection_r;
	logic captureCompareSelect_r;
	logic [7:0] edgeSelectControl_r;
	logic [7:0] channelIrqMask_r;
	logic [NUM_CHAN-1:0] captureFlag_r;
	logic [15:0] captureTime_r [NUM_CHAN];
	logic [15:0] pendTime_r [NUM_CHAN];
	logic [NUM_CHAN-1:0] pendValid_r;
	logic [NUM_CHAN-1:0] readBlock_r;
	logic [NUM_CHAN-1:0] pinSync1_r;
	logic [NUM_CHAN-1:0] pinSync2_r;
	logic [NUM_CHAN-1:0] pinPrev_r;
	logic modeSync1_r;
	logic modeSync2_r;
	logic [NUM_CHAN-1:0] chanEnable;
	logic [NUM_CHAN-1:0] captureEvent;
	logic [NUM_CHAN-1:0] highRead;
	logic [NUM_CHAN-1:0] timerInput;
	logic [NUM_CHAN-1:0] pinIsOutput;
	logic softCapture;
	logic sharedCapMode;
	logic wrCountHi;
	logic wrCountLo;
	logic [7:0] rdData_nxt;

	// Special mode strap is asynchronous: two flops before use
	always_ff @(posedge core_clk) begin
		modeSync1_r <= specialMode;
		modeSync2_r <= modeSync1_r;
	end

	// Pin synchronizer plus one more stage for edge history
	always_ff @(posedge core_clk) begin
		pinSync1_r <= portPinIn;
		pinSync2_r <= pinSync1_r;
		pinPrev_r <= pinSync2_r;
	end

	assign sharedCapMode = captureCompareSelect_r;
	assign softCapture = regWrEn && portDirection_r[`TCU_BIT_SHARED_DIR] && sharedCapMode
		&& (regAddr == `TCU_ADDR_SHARED_HI || regAddr == `TCU_ADDR_SHARED_LO)
		&& regWrData[`TCU_SOFT_CAP_BIT];

	// Per-channel enable, edge detect and high-byte read decode
	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			chanEnable[i] = (edgeSelectControl_r[2*i +: 2] != 2'h0) && (i != SH || sharedCapMode);
			captureEvent[i] = chanEnable[i] && (
				(edgeSelectControl_r[2*i] && pinSync2_r[i] && !pinPrev_r[i]) ||
				(edgeSelectControl_r[2*i+1] && !pinSync2_r[i] && pinPrev_r[i]));
			highRead[i] = 1'b0;
			timerInput[i] = (i == SH) ? (sharedCapMode && chanEnable[i]) : chanEnable[i];
		end
		captureEvent[SH] = captureEvent[SH] || softCapture;
		highRead[0] = regRdEn && (regAddr == `TCU_ADDR_CAP1_HI);
		highRead[1] = regRdEn && (regAddr == `TCU_ADDR_CAP2_HI);
		highRead[2] = regRdEn && (regAddr == `TCU_ADDR_CAP3_HI);
		highRead[SH] = regRdEn && (regAddr == `TCU_ADDR_SHARED_HI);
	end

	// Prescale divider; a tick advances the counter
	assign countTick = (preDiv_r == tcu_pkg::tcuPrescaleTerm(prescaleSelect_r));
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			preDiv_r <= 4'h0;
		end else if (countTick) begin
			preDiv_r <= 4'h0;
		end else begin
			preDiv_r <= preDiv_r + 4'h1;
		end
	end

	assign wrCountHi = regWrEn && modeSync2_r && regAddr == `TCU_ADDR_COUNT_HI;
	assign wrCountLo = regWrEn && modeSync2_r && regAddr == `TCU_ADDR_COUNT_LO;

	// Free-running counter; normal-mode writes never reach it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			freeCount_r <= `TCU_RESET_COUNT;
		end else if (wrCountHi) begin
			freeCount_r <= {regWrData, freeCount_r[7:0]};
		end else if (wrCountLo) begin
			freeCount_r <= {freeCount_r[15:8], regWrData};
		end else if (countTick) begin
			freeCount_r <= freeCount_r + 16'h0001;
		end
	end

	// Overflow flag: set beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			overflowFlag_r <= 1'b0;
		end else if (countTick && freeCount_r == `TCU_COUNT_MAX && !wrCountHi && !wrCountLo) begin
			overflowFlag_r <= 1'b1;
		end else if (regWrEn && regAddr == `TCU_ADDR_OVF_FLAGS && regWrData[`TCU_BIT_OVF_FLAG]) begin
			overflowFlag_r <= 1'b0;
		end
	end

	// Reset-window counter for the one-time prescale write
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bootCycles_r <= 7'h00;
		end else if (bootCycles_r != `TCU_PRESCALE_WINDOW) begin
			bootCycles_r <= bootCycles_r + 7'h01;
		end
	end

	// Overflow mask and prescale; normal mode locks prescale after one write or 64 cycles
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			overflowIrqEnable_r <= 1'b0;
			prescaleSelect_r <= tcu_pkg::TCU_DIV1;
			prescaleWritten_r <= 1'b0;
		end else if (regWrEn && regAddr == `TCU_ADDR_OVF_MASK) begin
			overflowIrqEnable_r <= regWrData[`TCU_BIT_OVF_IRQ_EN];
			if (modeSync2_r || (!prescaleWritten_r && bootCycles_r != `TCU_PRESCALE_WINDOW)) begin
				prescaleSelect_r <= tcu_pkg::tcu_prescale_t'(regWrData[1:0]);
				prescaleWritten_r <= 1'b1;
			end
		end
	end

	// Port latch, direction, shared select, edge control and channel mask
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			portLatch_r <= `TCU_RESET_BYTE;
			portDirection_r <= `TCU_RESET_BYTE;
			captureCompareSelect_r <= 1'b0;
			edgeSelectControl_r <= `TCU_RESET_BYTE;
			channelIrqMask_r <= `TCU_RESET_BYTE;
		end else if (regWrEn) begin
			case (regAddr)
				`TCU_ADDR_PORT_DATA: portLatch_r <= regWrData;
				`TCU_ADDR_PORT_DIR: portDirection_r <= regWrData;
				`TCU_ADDR_SHARED_SEL: captureCompareSelect_r <= regWrData[`TCU_BIT_CAP_CMP_SEL];
				`TCU_ADDR_EDGE_CTL: edgeSelectControl_r <= regWrData;
				`TCU_ADDR_CHAN_MASK: channelIrqMask_r <= regWrData;
				default: ;
			endcase
		end
	end

	// Channel flags: edge set wins over a write-one clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			captureFlag_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				if (captureEvent[i]) begin
					captureFlag_r[i] <= 1'b1;
				end else if (regWrEn && regAddr == `TCU_ADDR_CHAN_FLAGS && regWrData[i]) begin
					captureFlag_r[i] <= 1'b0;
				end
			end
		end
	end

	// Read block covers the high-read cycle and the one after it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			readBlock_r <= '0;
			pendValid_r <= '0;
		end else begin
			readBlock_r <= highRead;
			for (int i = 0; i < NUM_CHAN; i++) begin
				if (highRead[i] || readBlock_r[i]) begin
					pendValid_r[i] <= pendValid_r[i] || captureEvent[i];
				end else begin
					pendValid_r[i] <= 1'b0;
				end
			end
		end
	end

	// Capture storage keeps its value through reset; count sampled before it advances
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (highRead[i] || readBlock_r[i]) begin
				if (captureEvent[i]) begin
					pendTime_r[i] <= freeCount_r;
				end
			end else if (captureEvent[i]) begin
				captureTime_r[i] <= freeCount_r;
			end else if (pendValid_r[i]) begin
				captureTime_r[i] <= pendTime_r[i];
			end else if (i == SH && regWrEn && !sharedCapMode && regAddr == `TCU_ADDR_SHARED_HI) begin
				captureTime_r[i] <= {regWrData, captureTime_r[i][7:0]};
			end else if (i == SH && regWrEn && !sharedCapMode && regAddr == `TCU_ADDR_SHARED_LO) begin
				captureTime_r[i] <= {captureTime_r[i][15:8], regWrData};
			end
		end
	end

	// Pins: timer inputs are never driven; latch only reaches general-purpose outputs
	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			pinIsOutput[i] = portDirection_r[i] && !timerInput[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			portPinOut <= '0;
			portPinOe <= '0;
		end else begin
			portPinOut <= portLatch_r[NUM_CHAN-1:0] & pinIsOutput;
			portPinOe <= pinIsOutput;
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb begin
		rdData_nxt = 8'h00;
		case (regAddr)
			`TCU_ADDR_PORT_DATA: begin
				for (int i = 0; i < NUM_CHAN; i++) begin
					rdData_nxt[i] = pinIsOutput[i] ? portPinOut[i] : pinSync2_r[i];
				end
			end
			`TCU_ADDR_PORT_DIR: rdData_nxt = portDirection_r;
			`TCU_ADDR_COUNT_HI: rdData_nxt = freeCount_r[15:8];
			`TCU_ADDR_COUNT_LO: rdData_nxt = freeCount_r[7:0];
			`TCU_ADDR_CAP1_HI: rdData_nxt = captureTime_r[0][15:8];
			`TCU_ADDR_CAP1_LO: rdData_nxt = captureTime_r[0][7:0];
			`TCU_ADDR_CAP2_HI: rdData_nxt = captureTime_r[1][15:8];
			`TCU_ADDR_CAP2_LO: rdData_nxt = captureTime_r[1][7:0];
			`TCU_ADDR_CAP3_HI: rdData_nxt = captureTime_r[2][15:8];
			`TCU_ADDR_CAP3_LO: rdData_nxt = captureTime_r[2][7:0];
			`TCU_ADDR_SHARED_HI: rdData_nxt = captureTime_r[SH][15:8];
			`TCU_ADDR_SHARED_LO: rdData_nxt = captureTime_r[SH][7:0];
			`TCU_ADDR_EDGE_CTL: rdData_nxt = edgeSelectControl_r;
			`TCU_ADDR_CHAN_MASK: rdData_nxt = channelIrqMask_r;
			`TCU_ADDR_CHAN_FLAGS: rdData_nxt[NUM_CHAN-1:0] = captureFlag_r;
			`TCU_ADDR_OVF_MASK: rdData_nxt = {overflowIrqEnable_r, 5'h00, prescaleSelect_r};
			`TCU_ADDR_OVF_FLAGS: rdData_nxt[`TCU_BIT_OVF_FLAG] = overflowFlag_r;
			`TCU_ADDR_SHARED_SEL: rdData_nxt[`TCU_BIT_CAP_CMP_SEL] = captureCompareSelect_r;
			default: rdData_nxt = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= rdData_nxt;
		end else begin
			regRdData <= 8'h00;
		end
	end

	// Interrupt requests are levels straight from flags and enables
	assign overflowIrqReq = overflowIrqEnable_r && overflowFlag_r;
	always_comb begin
		captureIrqReq = captureFlag_r & channelIrqMask_r[NUM_CHAN-1:0];
		captureIrqReq[SH] = captureIrqReq[SH] && sharedCapMode;
	end
endmodule

// ===== bench/tcu_pin_model.sv
// Far-side pin sources for the capture timer port
module tcu_pin_model (
	input wire logic core_clk, // Bus clock
	input wire logic [3:0] pinLevel, // Level the far side wants
	input wire logic [3:0] portPinOut, // Device driver levels
	input wire logic [3:0] portPinOe, // Device output enables
	output logic [3:0] portPinIn // Resolved wire levels
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] drvLevel = 4'h0;
	// Outside sources move only just after a clock edge
	always @(posedge core_clk) drvLevel <= pinLevel;
	// A pin the device drives is released by the far side, so no contention
	assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & drvLevel);
endmodule

// ===== bench/tcu_monitor.sv
// Port-level checks for the capture timer
module tcu_monitor (
	input wire logic core_clk, // Bus clock
	input wire logic rst_n, // Reset, active low
	input wire logic [7:0] regAddr, // Address
	input wire logic [7:0] regWrData, // Write data
	input wire logic regWrEn, // Write strobe
	input wire logic regRdEn, // Read strobe
	input wire logic [7:0] regRdData, // Read data
	input wire logic [3:0] portPinIn, // Pin levels
	input wire logic [3:0] portPinOut, // Driver levels
	input wire logic [3:0] portPinOe, // Output enables
	input wire logic overflowIrqReq, // Overflow request
	input wire logic [3:0] captureIrqReq // Channel requests
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Read data may only stand in the slot after a strobe
	chk_read_data_slot: assert property (
		regRdData != 8'h00 |-> $past(regRdEn)) else $error("read data outside its slot");
	// Clearing the overflow enable drops the request at once
	chk_ovf_irq_mask: assert property (
		regWrEn && regAddr == 8'h24 && !regWrData[7] |=> !overflowIrqReq) else $error("overflow request not masked");
	// Only a one written to the flag or a mask write may drop it
	chk_ovf_flag_hold: assert property (
		overflowIrqReq && !(regWrEn && (regAddr == 8'h24 || regAddr == 8'h25 && regWrData[7])) |=> overflowIrqReq)
		else $error("overflow flag lost");
	// Writing zero to a channel flag leaves it standing
	chk_cap_flag_hold: assert property (
		regWrEn && regAddr == 8'h23 && !regWrData[0] && captureIrqReq[0] |=> captureIrqReq[0])
		else $error("channel flag cleared by zero");
	// A request rises only from a mask write or a pin change seen through the synchroniser
	chk_cap_rise_cause: assert property (
		$rose(captureIrqReq[0]) |-> ($past(regWrEn) && $past(regAddr) == 8'h22)
		|| ($past(portPinIn[0], 3) != $past(portPinIn[0], 4)))
		else $error("channel request without cause");
	// A cleared channel enable silences its request
	chk_cap_irq_mask: assert property (
		regWrEn && regAddr == 8'h22 && !regWrData[1] |=> !captureIrqReq[1]) else $error("channel request not masked");
	// Shared channel requests only while capture is selected
	chk_shared_sel_irq: assert property (
		regWrEn && regAddr == 8'h26 && !regWrData[2] |=> !captureIrqReq[3]) else $error("shared request in compare use");
	// An undriven pin shows a quiet driver
	chk_idle_driver: assert property (
		!portPinOe[3] |-> !portPinOut[3]) else $error("driver level on released pin");
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the capture timer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, lastRd, rnd = 8'h24, pins;
	logic regWrEn = 1'b0, regRdEn = 1'b0, specialMode = 1'b0, overflowIrqReq, rdDue = 1'b0;
	logic [3:0] portPinIn, portPinOut, portPinOe, captureIrqReq, pinLevel = 4'h0;
	logic [1:0] md;
	logic [15:0] capA, capB;
	logic [23:0] rdQ[$];
	int miscompares = 0, compares = 0;
	always #5 core_clk = ~core_clk;
	tcu_pin_model pinSide (.core_clk(core_clk), .pinLevel(pinLevel), .portPinOut(portPinOut), .portPinOe(portPinOe),
		.portPinIn(portPinIn));
	tcu_timer_capture dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .specialMode(specialMode),
		.portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe), .overflowIrqReq(overflowIrqReq),
		.captureIrqReq(captureIrqReq));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmpVal(input string what, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask
	// Expected value travels with the read; a zero mask means fetch only
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge core_clk);
		rdQ.push_back({a, m, e});
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
	endtask
	task automatic rdw(input logic [7:0] a, output logic [7:0] v);
		rd(a, 8'h00, 8'h00);
		@(negedge core_clk);
		#1 v = lastRd;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chkIrq(input logic [3:0] e);
		@(negedge core_clk);
		cmpVal("irq", {12'h000, e}, {12'h000, captureIrqReq});
	endtask
	// Read data stands only in the cycle after the strobe, so look mid-cycle there
	always @(negedge core_clk) begin
		if (rdDue) begin
			lastRd = regRdData;
			if (rdQ[0][15:8] != 8'h00)
				cmpVal($sformatf("read %h", rdQ[0][23:16]), {8'h00, rdQ[0][7:0]}, {8'h00, regRdData & rdQ[0][15:8]});
			void'(rdQ.pop_front());
		end
		rdDue = regRdEn;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		wr(8'h24, 8'h01);
		rd(8'h21, 8'h00, 8'hFF);
		rd(8'h23, 8'h00, 8'h0F);
		idle(70);
		wr(8'h24, 8'h83);
		rd(8'h24, 8'h81, 8'h83);
		// Special mode lets the count be preset just short of wrap
		specialMode <= 1'b1;
		idle(3);
		wr(8'h0E, 8'hFF);
		wr(8'h0F, 8'hFF);
		idle(8);
		rd(8'h25, 8'h80, 8'h80);
		@(negedge core_clk);
		cmpVal("ovf", 16'h0001, {15'h0000, overflowIrqReq});
		specialMode <= 1'b0;
		idle(3);
		wr(8'h0E, 8'hFF);
		rd(8'h0E, 8'h00, 8'hFF);
		wr(8'h24, 8'h00);
		wr(8'h25, 8'h80);
		rd(8'h25, 8'h00, 8'h80);
		// Every edge mode on two channels with simultaneous edges
		for (int m = 0; m < 4; m++) begin
			md = 2'(m);
			wr(8'h21, {4'h0, md, md});
			wr(8'h23, 8'h0F);
			pinLevel <= 4'h3;
			idle(6);
			rd(8'h23, {6'h00, {2{md[0]}}}, 8'h03);
			rdw(8'h10, capA[15:8]);
			rdw(8'h11, capA[7:0]);
			rdw(8'h12, capB[15:8]);
			rdw(8'h13, capB[7:0]);
			if (md[0])
				cmpVal("same count", capA, capB);
			wr(8'h23, 8'h0F);
			pinLevel <= 4'h0;
			idle(6);
			rd(8'h23, {6'h00, {2{md[1]}}}, 8'h03);
		end
		// Edges sixteen cycles apart at divide by four
		pinLevel <= 4'h1;
		idle(16);
		pinLevel <= 4'h3;
		idle(6);
		rdw(8'h10, capA[15:8]);
		rdw(8'h11, capA[7:0]);
		rdw(8'h12, capB[15:8]);
		rdw(8'h13, capB[7:0]);
		cmpVal("prescale", capA + 16'h0004, capB);
		// Both channels fall in the cycle the first one's high byte is read: its transfer must wait, not vanish
		@(posedge core_clk);
		pinLevel <= 4'h0;
		idle(2);
		rdw(8'h10, capB[15:8]);
		rdw(8'h11, capB[7:0]);
		cmpVal("coherent pair", capA, capB);
		rdw(8'h10, capA[15:8]);
		rdw(8'h11, capA[7:0]);
		rdw(8'h12, capB[15:8]);
		rdw(8'h13, capB[7:0]);
		cmpVal("held capture", capB, capA);
		wr(8'h22, 8'h01);
		chkIrq(4'h1);
		wr(8'h23, 8'h0E);
		chkIrq(4'h1);
		wr(8'h23, 8'h01);
		chkIrq(4'h0);
		// Software capture on the shared channel
		wr(8'h01, 8'h08);
		wr(8'h26, 8'h04);
		wr(8'h22, 8'h08);
		wr(8'h1E, 8'h01);
		chkIrq(4'h8);
		wr(8'h23, 8'h08);
		wr(8'h26, 8'h00);
		wr(8'h1E, 8'h01);
		rd(8'h23, 8'h00, 8'h08);
		wr(8'h26, 8'h04);
		wr(8'h01, 8'h00);
		wr(8'h1E, 8'h01);
		rd(8'h23, 8'h00, 8'h08);
		wr(8'h26, 8'h00);
		// Random port traffic: capture pins read the wire, outputs read the driver
		wr(8'h01, 8'h0B);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			pins = lfsr(rnd);
			wr(8'h00, rnd);
			pinLevel <= pins[3:0];
			idle(5);
			rd(8'h00, {4'h0, rnd[3], pins[2:0]}, 8'h0F);
			// Look mid-cycle so the registered pin outputs have settled
			@(negedge core_clk);
			cmpVal("pin drive", {8'h00, 4'h8, rnd[3], 3'h0}, {8'h00, portPinOe, portPinOut});
		end
		// Mid-run reset: edge selects clear, capture contents survive, a late prescale write is ignored
		rdw(8'h10, capA[15:8]);
		rdw(8'h11, capA[7:0]);
		@(posedge core_clk);
		rst_n <= 1'b0;
		idle(3);
		rst_n <= 1'b1;
		rd(8'h21, 8'h00, 8'hFF);
		rdw(8'h10, capB[15:8]);
		rdw(8'h11, capB[7:0]);
		cmpVal("capture through reset", capA, capB);
		idle(70);
		wr(8'h24, 8'h03);
		rd(8'h24, 8'h00, 8'h03);
		final_report;
	end
endmodule
bind tcu_timer_capture tcu_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .portPinIn(portPinIn),
	.portPinOut(portPinOut), .portPinOe(portPinOe), .overflowIrqReq(overflowIrqReq), .captureIrqReq(captureIrqReq));
